// *** inc/tmac_pkg.sv ***
package tmac_pkg;

  // register byte offsets on the AHB-Lite slave
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] AUTH_OFS = 8'h04;
  localparam logic [7:0] CMD_OFS = 8'h08;
  localparam logic [7:0] PA_OFS = 8'h0c;
  localparam logic [7:0] PB_OFS = 8'h10;
  localparam logic [7:0] PC_OFS = 8'h14;
  localparam logic [7:0] VALUE_OFS = 8'h18;
  localparam logic [7:0] ACTUAL_OFS = 8'h1c;
  localparam logic [7:0] DATA_OFS = 8'h20;
  localparam logic [7:0] RID0_OFS = 8'h24;
  localparam logic [7:0] STATUS_OFS = 8'h34;
  localparam logic [7:0] ENC0_OFS = 8'h38;

  // configuration register bits
  localparam int CFG_COMMIT_REQ = 0;
  localparam int CFG_EXCL_UNAUTH = 1;
  localparam int CFG_FILE_PRESENT = 2;
  localparam int CFG_PLEDGE_OFF = 3;
  localparam int CFG_PLEDGE_KEY = 4;
  localparam logic [4:0] CFG_RESET = 5'h00;

  // authentication state bits
  localparam int AUTH_ACTIVE = 0;
  localparam int AUTH_PLEDGE_KEY = 1;
  localparam int AUTH_MAC_MODE = 2;
  localparam int AUTH_LIMIT = 3;
  localparam logic [3:0] AUTH_RESET = 4'h0;

  // command register fields
  localparam int CMD_CODE_LSB = 0;
  localparam int CMD_FILE_LSB = 8;
  localparam int CMD_KIND_LSB = 16;

  // command kinds
  localparam logic [3:0] K_START = 4'h0;
  localparam logic [3:0] K_VALUE = 4'h1;
  localparam logic [3:0] K_FETCH = 4'h2;
  localparam logic [3:0] K_APPEND = 4'h3;
  localparam logic [3:0] K_MODIFY = 4'h4;
  localparam logic [3:0] K_ERASE = 4'h5;
  localparam logic [3:0] K_PLEDGE = 4'h6;
  localparam logic [3:0] K_FINISH = 4'h7;
  localparam logic [3:0] K_CANCEL = 4'h8;

  // status register bits
  localparam int ST_BUSY = 0;
  localparam int ST_ONGOING = 1;
  localparam int ST_EMPTY = 2;
  localparam int ST_PLEDGED = 3;
  localparam int ST_REJECT = 4;
  localparam int ST_DATA_OPEN = 5;
  localparam int ST_PLEDGED_AUTH = 6;

  localparam int BLK_BITS = 128;
  localparam int STAGE_BLKS = 3;
  localparam int WORDS_PER_BLK = 4;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

  typedef enum logic [1:0] {S_IDLE, S_KEYS, S_ENC, S_EMIT} seq_e;

endpackage

// *** hw/transaction_mac_input_builder.sv ***
// Register access over AHB-Lite and the register addresses were left to the implementer.
module transaction_mac_input_builder (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // session key derivation
  output logic key_req,
  input wire logic key_done,
  // aes engine, session encryption key selected
  output logic aes_req,
  output logic [127:0] aes_block,
  input wire logic aes_done,
  input wire logic [127:0] aes_result,
  // cmac engine, session mac key selected
  output logic blk_valid,
  input wire logic blk_ready,
  output logic [127:0] blk_data,
  output logic cmac_final,
  output logic cmac_abort,
  // abort from other events
  input wire logic implicit_abort
);
  import tmac_pkg::*;

  logic dp_q;
  logic dp_wr_q;
  logic [7:0] dp_addr_q;
  logic [31:0] hrdata_q;
  logic [4:0] cfg_q;
  logic [3:0] auth_q;
  logic [23:0] pa_q;
  logic [23:0] pb_q;
  logic [23:0] pc_q;
  logic [31:0] value_q;
  logic [23:0] actual_q;
  logic [127:0] rid_q;
  seq_e state_q;
  logic [BLK_BITS*STAGE_BLKS-1:0] stage_q;
  logic [1:0] nblk_q;
  logic need_enc_q;
  logic [127:0] cur_q;
  logic [127:0] prev_q;
  logic [127:0] enc_q;
  logic pledged_q;
  logic pledged_auth_q;
  logic empty_q;
  logic ongoing_q;
  logic reject_q;
  logic data_open_q;
  logic [95:0] wbuf_q;
  logic [1:0] wcnt_q;
  logic busy;
  logic stall;
  logic cmd_wr;
  logic data_wr;
  logic [3:0] kind;
  logic [7:0] code;
  logic [7:0] file;
  logic [31:0] status;
  logic [31:0] rd_mux;
  logic upd_ok;
  logic upd_skip;
  logic pledge_rej;

  function automatic logic [23:0] le24(input logic [23:0] v);
    return {v[7:0], v[15:8], v[23:16]};
  endfunction

  assign busy = (state_q != S_IDLE);
  // commands and data wait while a block is still in flight to the engines
  assign stall = dp_q && dp_wr_q && busy && (dp_addr_q == CMD_OFS || dp_addr_q == DATA_OFS);
  assign hreadyout = !stall;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign cmd_wr = dp_q && dp_wr_q && !busy && dp_addr_q == CMD_OFS;
  assign data_wr = dp_q && dp_wr_q && !busy && dp_addr_q == DATA_OFS;
  assign kind = hwdata[CMD_KIND_LSB +: 4];
  assign code = hwdata[CMD_CODE_LSB +: 8];
  assign file = hwdata[CMD_FILE_LSB +: 8];
  assign blk_valid = (state_q == S_EMIT);
  assign blk_data = stage_q[BLK_BITS*STAGE_BLKS-1 -: BLK_BITS];
  assign aes_block = prev_q;

  // updates happen only inside a transaction and below the counter limit
  assign upd_skip = cfg_q[CFG_EXCL_UNAUTH] && !auth_q[AUTH_ACTIVE];
  assign upd_ok = ongoing_q && !auth_q[AUTH_LIMIT] && !upd_skip;
  assign pledge_rej = !ongoing_q
    || !cfg_q[CFG_FILE_PRESENT] || cfg_q[CFG_PLEDGE_OFF]
    || pledged_q
    || auth_q[AUTH_LIMIT]
    || (cfg_q[CFG_PLEDGE_KEY] && !(auth_q[AUTH_ACTIVE] && auth_q[AUTH_PLEDGE_KEY]))
    || (auth_q[AUTH_ACTIVE] && !auth_q[AUTH_MAC_MODE]);

  assign status = {25'h0, pledged_auth_q, data_open_q, reject_q, pledged_q, empty_q, ongoing_q, busy};

  always_comb begin
    rd_mux = 32'h0;
    unique case (haddr[7:0])
      CFG_OFS: rd_mux = {27'h0, cfg_q};
      AUTH_OFS: rd_mux = {28'h0, auth_q};
      PA_OFS: rd_mux = {8'h0, pa_q};
      PB_OFS: rd_mux = {8'h0, pb_q};
      PC_OFS: rd_mux = {8'h0, pc_q};
      VALUE_OFS: rd_mux = value_q;
      ACTUAL_OFS: rd_mux = {8'h0, actual_q};
      RID0_OFS: rd_mux = rid_q[127:96];
      RID0_OFS + 8'h04: rd_mux = rid_q[95:64];
      RID0_OFS + 8'h08: rd_mux = rid_q[63:32];
      RID0_OFS + 8'h0c: rd_mux = rid_q[31:0];
      STATUS_OFS: rd_mux = status;
      ENC0_OFS: rd_mux = enc_q[127:96];
      ENC0_OFS + 8'h04: rd_mux = enc_q[95:64];
      ENC0_OFS + 8'h08: rd_mux = enc_q[63:32];
      ENC0_OFS + 8'h0c: rd_mux = enc_q[31:0];
      default: rd_mux = 32'h0;
    endcase
  end

  // address phase capture; read data is sampled here so it leaves a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_q <= 1'b0;
      dp_wr_q <= 1'b0;
      dp_addr_q <= 8'h00;
      hrdata_q <= 32'h0;
    end else if (hready) begin
      dp_q <= hsel && htrans == HTRANS_NONSEQ;
      dp_wr_q <= hwrite;
      dp_addr_q <= haddr[7:0];
      if (hsel && htrans == HTRANS_NONSEQ && !hwrite) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  // software-written configuration and parameters
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q <= CFG_RESET;
      auth_q <= AUTH_RESET;
      pa_q <= 24'h0;
      pb_q <= 24'h0;
      pc_q <= 24'h0;
      value_q <= 32'h0;
      actual_q <= 24'h0;
      rid_q <= 128'h0;
    end else if (dp_q && dp_wr_q) begin
      unique case (dp_addr_q)
        CFG_OFS: cfg_q <= hwdata[4:0];
        AUTH_OFS: auth_q <= hwdata[3:0];
        PA_OFS: pa_q <= hwdata[23:0];
        PB_OFS: pb_q <= hwdata[23:0];
        PC_OFS: pc_q <= hwdata[23:0];
        VALUE_OFS: value_q <= hwdata;
        ACTUAL_OFS: actual_q <= hwdata[23:0];
        RID0_OFS: rid_q[127:96] <= hwdata;
        RID0_OFS + 8'h04: rid_q[95:64] <= hwdata;
        RID0_OFS + 8'h08: rid_q[63:32] <= hwdata;
        RID0_OFS + 8'h0c: rid_q[31:0] <= hwdata;
        default: ;
      endcase
    end
  end

  // transaction sequencer: builds the padded input and feeds the engines
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= S_IDLE;
      stage_q <= '0;
      nblk_q <= 2'd0;
      need_enc_q <= 1'b0;
      cur_q <= 128'h0;
      prev_q <= 128'h0;
      enc_q <= 128'h0;
      pledged_q <= 1'b0;
      pledged_auth_q <= 1'b0;
      empty_q <= 1'b1;
      ongoing_q <= 1'b0;
      reject_q <= 1'b0;
      data_open_q <= 1'b0;
      wbuf_q <= 96'h0;
      wcnt_q <= 2'd0;
      key_req <= 1'b0;
      aes_req <= 1'b0;
      cmac_final <= 1'b0;
      cmac_abort <= 1'b0;
    end else begin
      key_req <= 1'b0;
      aes_req <= 1'b0;
      cmac_final <= 1'b0;
      cmac_abort <= 1'b0;
      if (implicit_abort) begin
        // drop whatever is staged; the engine restarts from an empty input
        state_q <= S_IDLE;
        nblk_q <= 2'd0;
        cmac_abort <= 1'b1;
        ongoing_q <= cfg_q[CFG_FILE_PRESENT];
        empty_q <= 1'b1;
        cur_q <= 128'h0;
        pledged_q <= 1'b0;
        pledged_auth_q <= 1'b0;
        data_open_q <= 1'b0;
        wcnt_q <= 2'd0;
      end else begin
        unique case (state_q)
          S_IDLE: begin
            if (cmd_wr) begin
              reject_q <= 1'b0;
              data_open_q <= 1'b0;
              wcnt_q <= 2'd0;
              need_enc_q <= 1'b0;
              unique case (kind)
                K_VALUE, K_FETCH, K_APPEND, K_MODIFY, K_ERASE: begin
                  if (ongoing_q && auth_q[AUTH_LIMIT]) begin
                    reject_q <= 1'b1;
                  end else if (upd_ok) begin
                    nblk_q <= 2'd1;
                    data_open_q <= (kind == K_FETCH || kind == K_APPEND || kind == K_MODIFY);
                    state_q <= empty_q ? S_KEYS : S_EMIT;
                    key_req <= empty_q;
                    empty_q <= 1'b0;
                    if (kind == K_VALUE) begin
                      stage_q <= {code, file, value_q[7:0], value_q[15:8], value_q[23:16], value_q[31:24],
                                  80'h0, 256'h0};
                    end else if (kind == K_FETCH) begin
                      stage_q <= {code, file, le24(pa_q), le24(pb_q == 24'h0 ? actual_q : pb_q),
                                  64'h0, 256'h0};
                    end else if (kind == K_APPEND) begin
                      stage_q <= {code, file, le24(pa_q), le24(pb_q), 64'h0, 256'h0};
                    end else if (kind == K_MODIFY) begin
                      stage_q <= {code, file, le24(pa_q), le24(pb_q), le24(pc_q), 40'h0, 256'h0};
                    end else begin
                      stage_q <= {code, file, 112'h0, 256'h0};
                    end
                  end
                end
                K_PLEDGE: begin
                  if (pledge_rej) begin
                    reject_q <= 1'b1;
                  end else begin
                    pledged_q <= 1'b1;
                    pledged_auth_q <= auth_q[AUTH_ACTIVE];
                    // an unauthenticated id lives only in the staged input
                    cur_q <= auth_q[AUTH_ACTIVE] ? rid_q : 128'h0;
                    stage_q <= {code, rid_q, 128'h0, 120'h0};
                    nblk_q <= auth_q[AUTH_ACTIVE] ? 2'd3 : 2'd2;
                    need_enc_q <= auth_q[AUTH_ACTIVE];
                    empty_q <= 1'b0;
                    key_req <= empty_q;
                    aes_req <= !empty_q && auth_q[AUTH_ACTIVE];
                    state_q <= empty_q ? S_KEYS : (auth_q[AUTH_ACTIVE] ? S_ENC : S_EMIT);
                  end
                end
                K_FINISH: begin
                  if (ongoing_q && cfg_q[CFG_COMMIT_REQ] && !pledged_q) begin
                    reject_q <= 1'b1;
                  end else begin
                    if (pledged_auth_q) begin
                      prev_q <= cur_q;
                    end
                    cmac_final <= ongoing_q;
                    ongoing_q <= cfg_q[CFG_FILE_PRESENT];
                    empty_q <= 1'b1;
                    cur_q <= 128'h0;
                    pledged_q <= 1'b0;
                    pledged_auth_q <= 1'b0;
                  end
                end
                K_CANCEL: begin
                  cmac_abort <= 1'b1;
                  ongoing_q <= cfg_q[CFG_FILE_PRESENT];
                  empty_q <= 1'b1;
                  cur_q <= 128'h0;
                  pledged_q <= 1'b0;
                  pledged_auth_q <= 1'b0;
                end
                K_START: begin
                  ongoing_q <= cfg_q[CFG_FILE_PRESENT];
                  empty_q <= 1'b1;
                  cur_q <= 128'h0;
                  pledged_q <= 1'b0;
                  pledged_auth_q <= 1'b0;
                end
                default: reject_q <= 1'b1;
              endcase
            end else if (data_wr && data_open_q) begin
              // data is a whole number of blocks, so no tail padding exists
              if (wcnt_q == 2'd3) begin
                stage_q <= {wbuf_q, hwdata, 256'h0};
                nblk_q <= 2'd1;
                state_q <= S_EMIT;
              end else begin
                wbuf_q <= {wbuf_q[63:0], hwdata};
              end
              wcnt_q <= wcnt_q + 2'd1;
            end
          end
          S_KEYS: begin
            if (key_done) begin
              state_q <= need_enc_q ? S_ENC : S_EMIT;
              aes_req <= need_enc_q;
            end
          end
          S_ENC: begin
            if (aes_done) begin
              enc_q <= aes_result;
              stage_q[247:120] <= aes_result;
              state_q <= S_EMIT;
            end
          end
          S_EMIT: begin
            if (blk_ready) begin
              stage_q <= {stage_q[BLK_BITS*(STAGE_BLKS-1)-1:0], 128'h0};
              nblk_q <= nblk_q - 2'd1;
              if (nblk_q == 2'd1) begin
                state_q <= S_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

endmodule

// *** sim/tmac_checker.sv ***
module tmac_checker (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // watched ports
  input wire logic hresp,
  input wire logic key_req,
  input wire logic key_done,
  input wire logic aes_req,
  input wire logic [127:0] aes_block,
  input wire logic aes_done,
  input wire logic blk_valid,
  input wire logic blk_ready,
  input wire logic [127:0] blk_data,
  input wire logic cmac_final,
  input wire logic cmac_abort
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic keys_wait_q;
  logic aes_wait_q;
  // open from the cycle after a request until the answer strobe
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      keys_wait_q <= 1'b0;
      aes_wait_q <= 1'b0;
    end else begin
      keys_wait_q <= key_req | (keys_wait_q & ~key_done);
      aes_wait_q <= aes_req | (aes_wait_q & ~aes_done);
    end
  end
  sequence s_stall;
    blk_valid && !blk_ready;
  endsequence
  sequence s_held;
    blk_valid && $stable(blk_data);
  endsequence
  property p_okay;
    hresp == 1'b0;
  endproperty
  // an abort may legally withdraw the offered block
  property p_hold;
    s_stall ##1 !cmac_abort |-> s_held;
  endproperty
  property p_key_pulse;
    key_req |=> !key_req;
  endproperty
  property p_aes_pulse;
    aes_req |=> !aes_req;
  endproperty
  property p_keys_first;
    keys_wait_q |-> !blk_valid && !aes_req;
  endproperty
  property p_enc_first;
    aes_wait_q |-> !blk_valid && $stable(aes_block);
  endproperty
  property p_final_idle;
    cmac_final |-> !blk_valid && !cmac_abort;
  endproperty
  property p_abort_idle;
    cmac_abort |-> !blk_valid ##1 !cmac_abort;
  endproperty
  a_okay: assert property (p_okay) else $error("hresp not okay");
  a_hold: assert property (p_hold) else $error("offered block dropped or changed");
  a_key_pulse: assert property (p_key_pulse) else $error("key request longer than one cycle");
  a_aes_pulse: assert property (p_aes_pulse) else $error("aes request longer than one cycle");
  a_keys_first: assert property (p_keys_first) else $error("stream before session keys");
  a_enc_first: assert property (p_enc_first) else $error("stream or id moved during encryption");
  a_final_idle: assert property (p_final_idle) else $error("final while stream busy");
  a_abort_idle: assert property (p_abort_idle) else $error("abort while stream busy");
endmodule

// *** sim/engine_model.sv ***
module engine_model #(
  parameter logic [127:0] ENC_MASK = 128'h3c5a96e10f87d2b46a19c3e57b2048fd
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // key derivation and cipher
  input wire logic key_req,
  output logic key_done,
  input wire logic aes_req,
  input wire logic [127:0] aes_block,
  output logic aes_done,
  output logic [127:0] aes_result,
  // mac stream
  input wire logic blk_valid,
  output logic blk_ready,
  input wire logic [127:0] blk_data,
  input wire logic cmac_final,
  input wire logic cmac_abort
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [127:0] blks[$];
  logic [127:0] aes_in;
  logic [2:0] key_sh;
  logic [1:0] aes_sh;
  logic [3:0] cyc;
  int n_key = 0;
  int n_final = 0;
  int n_abort = 0;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_sh <= 3'h0;
      aes_sh <= 2'h0;
      cyc <= 4'h0;
      key_done <= 1'b0;
      aes_done <= 1'b0;
      blk_ready <= 1'b0;
      aes_result <= 128'h0;
      aes_in <= 128'h0;
    end else begin
      cyc <= cyc + 4'h1;
      // alternates quick accepts with stalls of several cycles
      blk_ready <= cyc[0] & cyc[3];
      key_sh <= {key_sh[1:0], key_req};
      key_done <= key_sh[2];
      aes_sh <= {aes_sh[0], aes_req};
      aes_done <= aes_sh[1];
      // stand-in cipher; result lines toggle when not answering
      aes_result <= aes_sh[1] ? aes_in ^ ENC_MASK : ~aes_result;
      if (aes_req) aes_in <= aes_block;
      if (blk_valid && blk_ready) blks.push_back(blk_data);
      if (key_req) n_key++;
      if (cmac_final) n_final++;
      if (cmac_abort) n_abort++;
    end
  end
endmodule

// *** sim/transaction_mac_input_builder_tb.sv ***
module transaction_mac_input_builder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tmac_pkg::*;
  localparam logic [127:0] MASK = 128'h5ac3e1960f2d874b19a6e53c207bfd84;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, implicit_abort;
  logic [31:0] haddr, hwdata, hrdata, rd, val;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic key_req, key_done, aes_req, aes_done, blk_valid, blk_ready, cmac_final, cmac_abort;
  logic [127:0] aes_block, aes_result, blk_data, id, prev, dw;
  logic [7:0] code, file;
  logic [23:0] idx, cnt, len;
  logic [4:0] cfgs[5] = '{5'h01, 5'h0d, 5'h05, 5'h15, 5'h05};
  logic [3:0] auths[5] = '{4'h0, 4'h0, 4'h8, 4'h0, 4'h1};
  int errors, n_compared, seed, nb, ref_n, b0;
  assign hready = hreadyout;
  transaction_mac_input_builder transaction_mac_input_builder_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .key_req(key_req),
    .key_done(key_done), .aes_req(aes_req), .aes_block(aes_block), .aes_done(aes_done),
    .aes_result(aes_result), .blk_valid(blk_valid), .blk_ready(blk_ready), .blk_data(blk_data),
    .cmac_final(cmac_final), .cmac_abort(cmac_abort), .implicit_abort(implicit_abort));
  engine_model #(.ENC_MASK(MASK)) engine_model_inst (.hclk(hclk), .hresetn(hresetn), .key_req(key_req),
    .key_done(key_done), .aes_req(aes_req), .aes_block(aes_block), .aes_done(aes_done),
    .aes_result(aes_result), .blk_valid(blk_valid), .blk_ready(blk_ready), .blk_data(blk_data),
    .cmac_final(cmac_final), .cmac_abort(cmac_abort));
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // ready is judged just before the edge it applies to
  task automatic waitrdy();
    logic r;
    do begin
      @(negedge hclk);
      r = hreadyout;
      rd = hrdata;
      @(posedge hclk);
    end while (r !== 1'b1);
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    waitrdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    waitrdy();
  endtask
  // waits for the stream to drain; a hang counts as a mismatch
  task automatic settle();
    int t;
    t = 0;
    do bus(STATUS_OFS, 1'b0, 32'h0); while (rd[ST_BUSY] !== 1'b0 && ++t < 100);
    if (rd[ST_BUSY] !== 1'b0) begin
      errors++;
      $display("[FAIL] busy expected 0 seen %b", rd[ST_BUSY]);
    end
    nb = engine_model_inst.blks.size() - b0;
  endtask
  task automatic cmd(input logic [3:0] k);
    b0 = engine_model_inst.blks.size();
    bus(CMD_OFS, 1'b1, {12'h0, k, file, code});
    settle();
  endtask
  // multibyte parameters enter the input lowest byte first
  function automatic logic [23:0] le(input logic [23:0] v);
    return {v[7:0], v[15:8], v[23:16]};
  endfunction
  task automatic setup(input logic [4:0] c, input logic [3:0] a);
    bus(CFG_OFS, 1'b1, {27'h0, c});
    bus(AUTH_OFS, 1'b1, {28'h0, a});
    code = 8'($random(seed));
    file = 8'($random(seed));
    cmd(K_START);
  endtask
  // identity bytes repeat within a word, so word byte order cannot matter
  task automatic load_id();
    for (int i = 0; i < 4; i++) begin
      id[127 - 32 * i -: 32] = {4{8'($random(seed))}};
      bus(RID0_OFS + 8'(4 * i), 1'b1, id[127 - 32 * i -: 32]);
    end
  endtask
  function automatic logic [127:0] got(input int k);
    return engine_model_inst.blks[engine_model_inst.blks.size() - nb + k];
  endfunction
  function automatic logic [127:0] pl_exp(input int k, input logic auth);
    logic [383:0] s;
    s = auth ? {code, id, prev ^ MASK, 120'h0} : {code, id, 248'h0};
    return s[383 - 128 * k -: 128];
  endfunction
  initial begin
    repeat (20000) @(posedge hclk);
    errors++;
    summarize();
  end
  initial begin
    seed = 32'h7a6ddaa7;
    errors = 0;
    n_compared = 0;
    prev = 128'h0;
    {hresetn, hsel, hwrite, implicit_abort, haddr, hwdata, htrans} = '0;
    hsize = 3'b010;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("prev_id", 128'h0, aes_block);
    bus(CFG_OFS, 1'b0, 32'h0);
    chk("cfg", 128'h0, rd);
    setup(5'h04, 4'h0);
    ref_n = engine_model_inst.n_key;
    val = $random(seed);
    bus(VALUE_OFS, 1'b1, val);
    cmd(K_VALUE);
    chk("value_blocks", 1, nb);
    chk("value_block", {code, file, val[7:0], val[15:8], val[23:16], val[31:24], 80'h0}, got(0));
    chk("key_reqs", ref_n + 1, engine_model_inst.n_key);
    cmd(K_ERASE);
    chk("erase_block", {code, file, 112'h0}, got(0));
    chk("key_reqs", ref_n + 1, engine_model_inst.n_key);
    idx = 24'($random(seed));
    cnt = 24'($random(seed));
    bus(PA_OFS, 1'b1, {8'h0, idx});
    bus(PB_OFS, 1'b1, 32'h0);
    bus(ACTUAL_OFS, 1'b1, {8'h0, cnt});
    b0 = engine_model_inst.blks.size();
    bus(CMD_OFS, 1'b1, {12'h0, K_FETCH, file, code});
    // data follows at once, so the first word meets the busy stall
    for (int i = 0; i < 4; i++) begin
      dw[127 - 32 * i -: 32] = $random(seed);
      bus(DATA_OFS, 1'b1, dw[127 - 32 * i -: 32]);
    end
    settle();
    chk("fetch_blocks", 2, nb);
    chk("fetch_head", {code, file, idx[7:0], idx[15:8], idx[23:16], cnt[7:0], cnt[15:8], cnt[23:16], 64'h0},
      got(0));
    chk("fetch_data", dw, got(1));
    len = 24'($random(seed));
    bus(PB_OFS, 1'b1, {8'h0, cnt});
    bus(PC_OFS, 1'b1, {8'h0, len});
    cmd(K_APPEND);
    chk("append_head", {code, file, le(idx), le(cnt), 64'h0}, got(0));
    cmd(K_MODIFY);
    chk("modify_head", {code, file, le(idx), le(cnt), le(len), 40'h0}, got(0));
    ref_n = engine_model_inst.n_abort;
    cmd(K_CANCEL);
    chk("abort", ref_n + 1, engine_model_inst.n_abort);
    $display("test stream_layouts done");
    setup(5'h05, 4'h0);
    load_id();
    cmd(K_PLEDGE);
    chk("pledge_blocks", 2, nb);
    for (int k = 0; k < 2; k++) chk("pledge_block", pl_exp(k, 1'b0), got(k));
    cmd(K_PLEDGE);
    chk("second_pledge", {1'b1, 32'h0}, {rd[ST_REJECT], nb});
    ref_n = engine_model_inst.n_final;
    cmd(K_FINISH);
    chk("final", ref_n + 1, engine_model_inst.n_final);
    chk("prev_kept", 128'h0, aes_block);
    setup(5'h05, 4'h0);
    cmd(K_FINISH);
    chk("finish_refused", {1'b1, 32'h0, ref_n + 1}, {rd[ST_REJECT], nb, engine_model_inst.n_final});
    cmd(K_CANCEL);
    $display("test pledge_unauth done");
    for (int i = 0; i < 5; i++) begin
      setup(cfgs[i], auths[i]);
      cmd(K_PLEDGE);
      chk("pledge_refused", {1'b1, 32'h0}, {rd[ST_REJECT], nb});
      cmd(K_CANCEL);
    end
    $display("test pledge_refusals done");
    for (int t = 0; t < 2; t++) begin
      setup(5'h05, t ? 4'h7 : 4'h5);
      load_id();
      cmd(K_PLEDGE);
      chk("enc_input", prev, engine_model_inst.aes_in);
      chk("auth_blocks", 3, nb);
      for (int k = 0; k < 3; k++) chk("auth_block", pl_exp(k, 1'b1), got(k));
      dw = prev ^ MASK;
      for (int j = 0; j < 4; j++) begin
        bus(ENC0_OFS + 8'(4 * j), 1'b0, 32'h0);
        chk("enc_reg", dw[127 - 32 * j -: 32], rd);
      end
      cmd(K_FINISH);
      prev = id;
    end
    $display("test pledge_auth done");
    setup(5'h06, 4'h0);
    cmd(K_VALUE);
    chk("excluded", 0, nb);
    ref_n = engine_model_inst.n_abort;
    implicit_abort <= 1'b1;
    @(posedge hclk);
    implicit_abort <= 1'b0;
    repeat (4) @(posedge hclk);
    chk("implicit_abort", ref_n + 1, engine_model_inst.n_abort);
    $display("test exclude_abort done");
    summarize();
  end
endmodule
bind transaction_mac_input_builder tmac_checker tmac_checker_inst (.hclk(hclk), .hresetn(hresetn),
  .hresp(hresp), .key_req(key_req), .key_done(key_done), .aes_req(aes_req), .aes_block(aes_block),
  .aes_done(aes_done), .blk_valid(blk_valid), .blk_ready(blk_ready), .blk_data(blk_data),
  .cmac_final(cmac_final), .cmac_abort(cmac_abort));
